// File: logic/bqbank_pkg.sv
// constants, types and helper functions of the biquad bank and channel summer
package bqbank_pkg;
	localparam int NSEC = 12;
	localparam int NCH = 8;
	localparam int SW = 32;
	localparam int SEC_BYTES = 20;
	localparam int COEF_BYTES = 4;
	localparam int NBYTES = NSEC * SEC_BYTES;
	localparam int NBITS = NBYTES * 8;
	localparam int FRAC_BITS = 31;
	localparam int ALLOC_LSB = 5;
	localparam int SUM_LSB = 2;
	localparam logic [7:0] PAGE_LO = 8'h02;
	localparam logic [7:0] PAGE_HI = 8'h03;
	localparam logic [7:0] PAGE_HI_BASE = 8'h78;
	localparam logic [6:0] REG_FIRST = 7'h08;
	localparam logic [3:0] SEC_LAST = 4'hB;
	localparam logic [1:0] ALLOC_OFF = 2'h0;
	localparam logic [1:0] ALLOC_ONE = 2'h1;
	localparam logic [1:0] ALLOC_TWO = 2'h2;
	localparam logic [1:0] ALLOC_THREE = 2'h3;
	localparam logic [1:0] ALLOC_RST = 2'h2;
	localparam logic [1:0] SUM_OFF = 2'h0;
	localparam logic [1:0] SUM_PAIR = 2'h1;
	localparam logic [1:0] SUM_QUAD = 2'h2;
	localparam logic [1:0] SUM_RST = 2'h0;
	localparam logic [SW-1:0] N0_RST = 32'h7FFFFFFF;
	localparam logic signed [66:0] ROUND_ADD = 67'sh000000040000000;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PUSH} bqb_fsm_t;

	typedef struct packed {
		bqb_fsm_t st;
		logic [3:0] sec;
		logic [1:0] alloc;
		logic [1:0] sum;
		logic fresh;
		logic [NBITS-1:0] coef;
		logic [NSEC-1:0][SW-1:0] x1;
		logic [NSEC-1:0][SW-1:0] x2;
		logic [NSEC-1:0][SW-1:0] y1;
		logic [NSEC-1:0][SW-1:0] y2;
		logic [NCH-1:0][SW-1:0] inq;
		logic [NCH-1:0][SW-1:0] chv;
		logic [NCH-1:0][SW-1:0] buf0;
		logic [NCH-1:0][SW-1:0] buf1;
		logic v0;
		logic v1;
		logic in_rdy;
		logic busy;
	} bqb_state_t;

	// all-pass image: N0 near unity, every other coefficient zero
	function automatic logic [NBITS-1:0] bqb_coef_reset();
		logic [NBITS-1:0] v;
		int b;
		v = '0;
		for (int i = 0; i < NBYTES; i++) begin
			b = i % SEC_BYTES;
			if (b < COEF_BYTES) begin
				v[i*8 +: 8] = N0_RST[31-8*b -: 8];
			end
		end
		return v;
	endfunction

	// section to channel: {enable, channel index}
	function automatic logic [3:0] bqb_sec_map(input logic [1:0] alloc, input logic [3:0] s);
		logic [3:0] r;
		r = 4'h0;
		unique case (alloc)
			ALLOC_OFF: r = 4'h0;
			ALLOC_ONE: begin
				if (s < 4'h4) begin
					r = {1'b1, s[2:0]};
				end else if (s > 4'h7) begin
					r = {1'b1, 3'(s - 4'h4)};
				end
			end
			ALLOC_TWO: begin
				if (s < 4'h8) begin
					r = {2'b10, s[1:0]};
				end else begin
					r = {3'b110, s[0]};
				end
			end
			ALLOC_THREE: r = {2'b10, s[1:0]};
		endcase
		return r;
	endfunction
endpackage

// File: logic/bqbank_top.sv
// biquad bank with section allocation, channel summer and two-entry output buffer
`timescale 1ns/1ps
module bqbank_top
	import bqbank_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [NCH-1:0][SW-1:0] IN_DATA,
	input wire logic IN_VALID,
	output logic IN_READY,
	output logic [NCH-1:0][SW-1:0] OUT_DATA,
	output logic OUT_VALID,
	input wire logic OUT_READY,
	input wire logic COEF_WR,
	input wire logic [7:0] COEF_PAGE,
	input wire logic [6:0] COEF_REG,
	input wire logic [7:0] COEF_DATA,
	input wire logic ALLOC_CFG_WR,
	input wire logic SUM_CFG_WR,
	input wire logic [7:0] CFG_DATA,
	output logic [1:0] ALLOC_STATE,
	output logic [1:0] CHANNEL_SUM_SELECT,
	output logic BUSY
);
	bqb_state_t q;
	bqb_state_t n;
	logic [7:0] wr_idx;
	logic [7:0] sec_base;
	logic [3:0] map;
	logic [2:0] ch;
	logic signed [SW-1:0] xin;
	logic signed [SW-1:0] c0, c1, c2, c3, c4;
	logic signed [63:0] p0, p1, p2, p3, p4;
	logic signed [66:0] acc;
	logic signed [66:0] sh;
	logic signed [SW-1:0] y;
	logic [NCH-1:0][SW-1:0] summed;
	logic [32:0] s2;
	logic [33:0] s4;
	logic pop;
	logic room;

	// assembles a coefficient word, first byte most significant
	function automatic logic [SW-1:0] coef_word(input logic [NBITS-1:0] v, input int i);
		return {v[i*8 +: 8], v[(i+1)*8 +: 8], v[(i+2)*8 +: 8], v[(i+3)*8 +: 8]};
	endfunction

	assign IN_READY = q.in_rdy;
	assign OUT_DATA = q.buf0;
	assign OUT_VALID = q.v0;
	assign ALLOC_STATE = q.alloc;
	assign CHANNEL_SUM_SELECT = q.sum;
	assign BUSY = q.busy;

	always_comb begin
		n = q;
		wr_idx = (COEF_PAGE == PAGE_HI ? PAGE_HI_BASE : 8'h00) + {1'b0, COEF_REG} - {1'b0, REG_FIRST};
		sec_base = {4'h0, q.sec} * 8'd20;
		map = bqb_sec_map(q.alloc, q.sec);
		ch = map[2:0];
		xin = q.chv[ch];
		c0 = coef_word(q.coef, int'(sec_base));
		c1 = coef_word(q.coef, int'(sec_base) + 4);
		c2 = coef_word(q.coef, int'(sec_base) + 8);
		c3 = coef_word(q.coef, int'(sec_base) + 12);
		c4 = coef_word(q.coef, int'(sec_base) + 16);
		p0 = c0 * xin;
		p1 = c1 * $signed(q.x1[q.sec]);
		p2 = c2 * $signed(q.x2[q.sec]);
		p3 = c3 * $signed(q.y1[q.sec]);
		p4 = c4 * $signed(q.y2[q.sec]);
		acc = 67'(p0) + (67'(p1) <<< 1) + 67'(p2) + (67'(p3) <<< 1) + 67'(p4) + ROUND_ADD;
		sh = acc >>> FRAC_BITS;
		if (sh[66:31] != {36{sh[31]}}) begin
			y = sh[66] ? 32'sh80000000 : 32'sh7FFFFFFF;
		end else begin
			y = sh[31:0];
		end
		summed = IN_DATA;
		for (int k = 0; k < NCH; k++) begin
			s2 = 33'({IN_DATA[k & 6][SW-1], IN_DATA[k & 6]}) + 33'({IN_DATA[k | 1][SW-1], IN_DATA[k | 1]});
			s4 = 34'({{2{IN_DATA[0][SW-1]}}, IN_DATA[0]}) + 34'({{2{IN_DATA[1][SW-1]}}, IN_DATA[1]})
				+ 34'({{2{IN_DATA[2][SW-1]}}, IN_DATA[2]}) + 34'({{2{IN_DATA[3][SW-1]}}, IN_DATA[3]});
			if (q.sum == SUM_PAIR && k < 6) begin
				summed[k] = s2[32:1];
			end else if (q.sum == SUM_QUAD && k < 4) begin
				summed[k] = s4[33:2];
			end
		end
		if (COEF_WR && (COEF_PAGE == PAGE_LO || COEF_PAGE == PAGE_HI) && COEF_REG >= REG_FIRST) begin
			n.coef[wr_idx*8 +: 8] = COEF_DATA;
			n.fresh = 1'b0;
		end
		if (ALLOC_CFG_WR) begin
			n.alloc = CFG_DATA[ALLOC_LSB +: 2];
		end
		if (SUM_CFG_WR) begin
			n.sum = CFG_DATA[SUM_LSB +: 2];
		end
		pop = q.v0 && OUT_READY;
		room = !q.v1 || pop;
		if (pop) begin
			n.buf0 = q.buf1;
			n.v0 = q.v1;
			n.v1 = 1'b0;
		end
		unique case (q.st)
			ST_IDLE: begin
				if (IN_VALID) begin
					n.inq = IN_DATA;
					n.chv = summed;
					n.sec = 4'h0;
					n.st = ST_RUN;
					n.in_rdy = 1'b0;
					n.busy = 1'b1;
				end
			end
			ST_RUN: begin
				if (map[3]) begin
					n.chv[ch] = y;
					n.x1[q.sec] = xin;
					n.x2[q.sec] = q.x1[q.sec];
					n.y1[q.sec] = y;
					n.y2[q.sec] = q.y1[q.sec];
				end
				if (q.sec == SEC_LAST) begin
					n.st = ST_PUSH;
				end else begin
					n.sec = q.sec + 4'h1;
				end
			end
			ST_PUSH: begin
				if (room) begin
					if (!n.v0) begin
						n.buf0 = q.chv;
						n.v0 = 1'b1;
					end else begin
						n.buf1 = q.chv;
						n.v1 = 1'b1;
					end
					n.st = ST_IDLE;
					n.in_rdy = 1'b1;
					n.busy = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.alloc <= ALLOC_RST;
			q.sum <= SUM_RST;
			q.coef <= bqb_coef_reset();
			q.fresh <= 1'b1;
			q.in_rdy <= 1'b1;
		end else begin
			q <= n;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	AST_RESET_ALLPASS: assert property (q.fresh |-> q.coef == bqb_coef_reset())
		else $error("coefficients left the all-pass image without a write");
	AST_BYPASS: assert property (q.st == ST_PUSH && q.alloc == ALLOC_OFF && q.sum == SUM_OFF
		&& !ALLOC_CFG_WR |-> q.chv == q.inq)
		else $error("bypass frame was altered");
	AST_ALLOC_FIELD: assert property (ALLOC_CFG_WR |=> q.alloc == $past(CFG_DATA[6:5]))
		else $error("allocation field not taken from bits 6:5");
	AST_ONE_UNUSED: assert property (q.alloc == ALLOC_ONE && q.sec > 4'h3 && q.sec < 4'h8
		|-> !map[3])
		else $error("unused section enabled in one-per-channel mode");
	AST_ONE_HIGH: assert property (q.alloc == ALLOC_ONE && q.sec > 4'h7
		|-> map == {1'b1, 3'(q.sec - 4'h4)})
		else $error("upper sections misrouted in one-per-channel mode");
	AST_TWO_MAP: assert property (q.alloc == ALLOC_TWO |-> map[3] &&
		(q.sec < 4'h8 ? ch == {1'b0, q.sec[1:0]} : ch == {2'b10, q.sec[0]}))
		else $error("two-per-channel routing wrong");
	AST_THREE_MAP: assert property (q.alloc == ALLOC_THREE |-> map == {2'b10, q.sec[1:0]})
		else $error("three-per-channel routing wrong");
	AST_CASCADE_ORDER: assert property (q.st == ST_RUN && q.sec != SEC_LAST
		|=> q.st == ST_RUN && q.sec == $past(q.sec) + 4'h1)
		else $error("sections not visited in ascending order");
	AST_FRAME_LEN: assert property (q.st == ST_IDLE && IN_VALID |=> q.st == ST_RUN [*6] ##1
		q.st == ST_RUN [*6] ##1 q.st == ST_PUSH)
		else $error("frame did not pass twelve section slots");
	AST_COEF_WRITE: assert property (COEF_WR && COEF_PAGE == PAGE_LO && COEF_REG == REG_FIRST
		|=> q.coef[7:0] == $past(COEF_DATA))
		else $error("first coefficient byte not stored");
	AST_PAIR_SUM: assert property (q.st == ST_IDLE && IN_VALID && q.sum == SUM_PAIR
		|=> q.chv[0] == q.chv[1] && q.chv[4] == q.chv[5])
		else $error("pair averages differ");
	AST_QUAD_SUM: assert property (q.st == ST_IDLE && IN_VALID && q.sum == SUM_QUAD
		|=> q.chv[0] == q.chv[3] && q.chv[1] == q.chv[2])
		else $error("quad averages differ");

	COV_THREE_FRAME: cover property (q.alloc == ALLOC_THREE && q.st == ST_PUSH && room);
	COV_QUAD_FRAME: cover property (q.sum == SUM_QUAD && q.st == ST_PUSH && room);
	COV_BUF_FULL: cover property (q.v0 && q.v1 && !OUT_READY);
	COV_STALL: cover property (q.st == ST_PUSH && !room);
endmodule

// File: testbench/bqbank_sink.sv
// downstream sink model that takes finished frames, with a stall control
`timescale 1ns/1ps
module bqbank_sink (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic STALL,
	input wire logic OUT_VALID,
	output logic OUT_READY
);
	// ready follows the stall request one edge later, like a registered port
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			OUT_READY <= 1'b0;
		end else begin
			OUT_READY <= ~STALL;
		end
	end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the biquad bank and channel summer
`timescale 1ns/1ps
module testbench;
	import bqbank_pkg::*;
	logic clk, rst_b, in_valid, in_ready, out_valid, out_ready, busy, stall;
	logic coef_wr, alloc_wr, sum_wr;
	logic [7:0] coef_page, coef_data, cfg_data;
	logic [6:0] coef_reg;
	logic [1:0] alloc_state, sum_sel;
	logic [NCH-1:0][SW-1:0] in_data, out_data, f, e;
	int miscompares, num_checks, q, c;
	bqbank_top DUT (
		.CORE_CLK(clk),
		.RST_B(rst_b),
		.IN_DATA(in_data),
		.IN_VALID(in_valid),
		.IN_READY(in_ready),
		.OUT_DATA(out_data),
		.OUT_VALID(out_valid),
		.OUT_READY(out_ready),
		.COEF_WR(coef_wr),
		.COEF_PAGE(coef_page),
		.COEF_REG(coef_reg),
		.COEF_DATA(coef_data),
		.ALLOC_CFG_WR(alloc_wr),
		.SUM_CFG_WR(sum_wr),
		.CFG_DATA(cfg_data),
		.ALLOC_STATE(alloc_state),
		.CHANNEL_SUM_SELECT(sum_sel),
		.BUSY(busy)
	);
	bqbank_sink sink (
		.CORE_CLK(clk),
		.RST_B(rst_b),
		.STALL(stall),
		.OUT_VALID(out_valid),
		.OUT_READY(out_ready)
	);
	task automatic results();
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [255:0] g, input logic [255:0] x, input string m);
		num_checks++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	function automatic logic [NCH*SW-1:0] mk(input logic [SW-1:0] b);
		for (int k = 0; k < NCH; k++) begin
			mk[k*SW +: SW] = b + SW'(4 * k);
		end
	endfunction
	task automatic send(input logic [NCH*SW-1:0] d);
		int n;
		n = 0;
		@(posedge clk);
		in_valid <= 1'b1;
		in_data <= d;
		do begin
			@(negedge clk);
			n++;
		end while (in_ready !== 1'b1 && n < 100);
		@(posedge clk);
		in_valid <= 1'b0;
		in_data <= ~d;
		chk(256'(n < 100), 256'(1), "frame not taken");
	endtask
	task automatic recv(input logic [NCH*SW-1:0] x, input string m);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(out_valid === 1'b1 && out_ready === 1'b1) && n < 100);
		chk(out_data, x, m);
		@(posedge clk);
	endtask
	task automatic wr32(input logic [7:0] p, input logic [6:0] r, input logic [31:0] v);
		@(posedge clk);
		coef_wr <= 1'b1;
		coef_page <= p;
		for (int i = 0; i < 4; i++) begin
			coef_reg <= r + 7'(i);
			coef_data <= v[31-8*i -: 8];
			@(posedge clk);
		end
		coef_wr <= 1'b0;
	endtask
	task automatic cfg(input logic a, input logic s, input logic [7:0] d);
		@(posedge clk);
		alloc_wr <= a;
		sum_wr <= s;
		cfg_data <= d;
		@(posedge clk);
		alloc_wr <= 1'b0;
		sum_wr <= 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		miscompares++;
		results();
	end
	initial begin
		{rst_b, in_valid, stall, coef_wr, alloc_wr, sum_wr} = '0;
		{coef_page, coef_data, cfg_data, coef_reg} = '0;
		in_data = '0;
		miscompares = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(256'({alloc_state, sum_sel, in_ready, out_valid, busy}), 256'(7'h44), "reset");
		f = mk(32'hFFFFFFF0);
		q = 0;
		for (int k = 0; k < 4; k++) begin
			q += int'($signed(f[k]));
		end
		for (int s = 0; s < 3; s++) begin
			cfg(1'b0, 1'b1, 8'hF3 | 8'(s << 2));
			@(negedge clk);
			chk(256'(sum_sel), 256'(s), "sum select");
			e = f;
			for (int k = 0; k < 6; k++) begin
				if (s == 1) begin
					e[k] = SW'((int'($signed(f[k & 6])) + int'($signed(f[k | 1]))) >>> 1);
				end
				if (s == 2 && k < 4) begin
					e[k] = SW'(q >>> 2);
				end
			end
			send(f);
			recv(e, "summing");
		end
		cfg(1'b0, 1'b1, 8'hF3);
		wr32(PAGE_LO, REG_FIRST, 32'h40000000);
		wr32(PAGE_HI, 7'h6C, 32'h40000000);
		wr32(8'h04, REG_FIRST, 32'h00000000);
		for (int a = 0; a < 4; a++) begin
			cfg(1'b1, 1'b0, 8'h9F | 8'(a << 5));
			@(negedge clk);
			chk(256'(alloc_state), 256'(a), "allocation");
			e = f;
			c = 9 - 2 * a;
			if (a != 0) begin
				e[0] = {f[0][31], f[0][31:1]};
				e[c] = {f[c][31], f[c][31:1]};
			end
			send(f);
			recv(e, "allocated frame");
		end
		cfg(1'b1, 1'b0, 8'h00);
		stall <= 1'b1;
		send(f);
		send(~f);
		send(f ^ 256'h5);
		repeat (20) @(negedge clk);
		chk(256'({busy, in_ready, out_valid}), 256'(3'h5), "full buffer");
		chk(out_data, f, "head held");
		@(posedge clk);
		stall <= 1'b0;
		recv(f, "first out");
		recv(~f, "second out");
		recv(f ^ 256'h5, "third out");
		@(negedge clk);
		chk(256'(out_valid), 256'(0), "drained");
		results();
	end
endmodule
